// ===== hw/spmp_fifo.sv
// first-in first-out buffer with a registered output stage, valid/ready on both sides
// assumes one clock; clk_en low freezes all state
`timescale 1ns/10ps
module spmp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("spmp_fifo: DEPTH must be a power of two >= 2");
        if (WIDTH < 1) $error("spmp_fifo: WIDTH must be positive");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [AW:0] count_reg;
    logic out_valid_reg;
    logic [WIDTH-1:0] out_data_reg;

    // storage handshakes; the output stage refills whenever it is empty or being drained
    wire push = in_valid & in_ready;
    wire load = (count_reg != '0) & (~out_valid_reg | out_ready);
    assign in_ready = (count_reg != (AW + 1)'(DEPTH));
    assign out_valid = out_valid_reg;
    assign out_data = out_data_reg;

    // storage array, no reset needed on the data words
    always_ff @(posedge clk) begin
        if (clk_en && push) begin
            mem[wptr_reg] <= in_data;
        end
    end

    // pointers, fill count and output register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            count_reg <= '0;
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end else if (clk_en) begin
            if (push) wptr_reg <= wptr_reg + 1'b1;
            if (load) begin
                rptr_reg <= rptr_reg + 1'b1;
                out_data_reg <= mem[rptr_reg];
            end
            count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(load);
            if (load) out_valid_reg <= 1'b1;
            else if (out_ready) out_valid_reg <= 1'b0;
        end
    end
endmodule // spmp_fifo

// ===== hw/spmp_pkg.sv
// shared constants for the serial port with modem pins: register map, field positions, reset values, timing
// assumes a single 40 MHz pclk domain and an APB slave with an 8-bit byte address
package spmp_pkg;

    // register byte offsets, one aligned 32-bit word each
    localparam logic [7:0] SPMP_OFF_DATA = 8'h00;
    localparam logic [7:0] SPMP_OFF_MCTL = 8'h04;
    localparam logic [7:0] SPMP_OFF_MSTAT = 8'h08;
    localparam logic [7:0] SPMP_OFF_LINE = 8'h0c;
    localparam logic [7:0] SPMP_OFF_DIV = 8'h10;

    // modem_control_reg fields
    localparam int SPMP_MCTL_DTR = 0;
    localparam int SPMP_MCTL_RTS = 1;
    localparam int SPMP_MCTL_LOOP = 4;
    localparam int SPMP_MCTL_IR = 5;
    localparam int SPMP_MCTL_W = 6;
    localparam logic [5:0] SPMP_MCTL_RESET = 6'h00;

    // modem_status_reg fields: low nibble change flags, high nibble current levels (active high)
    localparam int SPMP_MS_CTS = 0;
    localparam int SPMP_MS_DSR = 1;
    localparam int SPMP_MS_RI = 2;
    localparam int SPMP_MS_DCD = 3;
    localparam int SPMP_MS_CUR = 4;

    // line status fields
    localparam int SPMP_LS_RXRDY = 0;
    localparam int SPMP_LS_OVR = 1;
    localparam int SPMP_LS_TXFULL = 2;
    localparam int SPMP_LS_TXIDLE = 3;
    localparam int SPMP_LS_STRAP = 4;

    // bit timing
    localparam int SPMP_CLK_HZ = 40_000_000;
    localparam int SPMP_BAUD_HZ = 115_200;
    localparam logic [15:0] SPMP_DIV_RESET = 16'(SPMP_CLK_HZ / SPMP_BAUD_HZ);
    localparam logic [15:0] SPMP_DIV_MIN = 16'h0004;
    localparam int SPMP_DATA_W = 8;
    localparam int SPMP_FIFO_DEPTH = 16;

    // shared by transmitter and receiver
    typedef enum logic [1:0] {
        SPMP_IDLE = 2'b00,
        SPMP_START = 2'b01,
        SPMP_BITS = 2'b10,
        SPMP_STOP = 2'b11
    } spmp_line_t;

endpackage

// ===== hw/spmp_port.sv
// first serial port: 8N1 transmitter and receiver, modem control outputs, modem status inputs,
// power-on strap sampling on the three output pins, APB register slave
// assumes all pins synchronous to pclk; the pad ring resolves the three two-way pins from their enables
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
// Overview of operation
// - The transmit pin sits at logic 1 after master reset and whenever infrared mode is selected.
// - While the host bus reset is low the transmit pin is released and sampled as a strap.
// - While the host bus reset is low the send-request and terminal-ready pins are released and sampled as straps.
// - Send-request goes low when its control bit is 1, and is inactive after master reset and in loop mode.
// - The modem's set-ready input, active low, is readable as a status bit.
// - The modem's clear-to-send input, active low, is readable as a status bit.
// - The modem's ring-indicate input, active low, is readable as a status bit.
// - The modem's carrier-detect input, active low, is readable as a status bit.
// - Serial data is received on the receive input and sent on the transmit output.
module spmp_port
    import spmp_pkg::*;
#(
    parameter int FIFO_DEPTH = SPMP_FIFO_DEPTH,
    parameter logic [15:0] DIV_RESET = SPMP_DIV_RESET
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // host bus reset, opens the strap window
    input wire logic host_bus_reset_n,
    // serial data
    input wire logic serial_rx_in,
    output logic serial_tx_out,
    output logic serial_tx_oe,
    input wire logic serial_tx_pin_in,
    // modem control outputs, two-way during the strap window
    output logic send_request_out_n,
    output logic send_request_oe,
    input wire logic send_request_pin_in,
    output logic terminal_ready_out_n,
    output logic terminal_ready_oe,
    input wire logic terminal_ready_pin_in,
    // modem status inputs
    input wire logic set_ready_in_n,
    input wire logic clear_to_send_in_n,
    input wire logic ring_indicate_in_n,
    input wire logic carrier_detect_in_n,
    // latched strap values
    output logic strap_opt_a,
    output logic strap_opt_b,
    output logic strap_opt_c
);
    initial begin
        if (DIV_RESET < SPMP_DIV_MIN) $error("spmp_port: DIV_RESET below minimum divisor");
    end

    // address match, used by read mux, error and side-effect decode
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    logic [SPMP_MCTL_W-1:0] mcr_reg;
    logic [15:0] div_reg;
    logic [3:0] ms_cur_reg;
    logic [3:0] ms_delta_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic hbr_prev_reg;
    logic [2:0] strap_samp_reg;
    logic [2:0] strap_reg;
    logic pins_oe_reg;
    logic tx_out_reg;
    logic rts_n_reg;
    logic dtr_n_reg;
    spmp_line_t tx_state_reg;
    logic [15:0] tx_cnt_reg;
    logic [2:0] tx_bit_reg;
    logic [7:0] tx_sh_reg;
    logic tx_line_reg;
    spmp_line_t rx_state_reg;
    logic [15:0] rx_cnt_reg;
    logic [2:0] rx_bit_reg;
    logic [7:0] rx_sh_reg;
    logic rx_s_reg;
    logic [7:0] rx_data_reg;
    logic rx_rdy_reg;
    logic rx_ovr_reg;

    // bus decode
    wire acc = psel & penable;
    wire hit_data = addr_is(paddr, SPMP_OFF_DATA);
    wire hit_mctl = addr_is(paddr, SPMP_OFF_MCTL);
    wire hit_mstat = addr_is(paddr, SPMP_OFF_MSTAT);
    wire hit_line = addr_is(paddr, SPMP_OFF_LINE);
    wire hit_div = addr_is(paddr, SPMP_OFF_DIV);
    wire hit_any = hit_data | hit_mctl | hit_mstat | hit_line | hit_div;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    // a data write into a full fifo is held in its access phase: back-pressure reaches the master
    wire wr_blocked = pwrite & hit_data & ~fifo_in_ready;
    wire pready_next = acc & ~pready_reg & ~wr_blocked;
    wire fire = acc & pready_reg;
    wire wr_fire = fire & pwrite;
    wire rd_fire = fire & ~pwrite;
    wire push_tx = wr_fire & hit_data;
    wire loop_mode = mcr_reg[SPMP_MCTL_LOOP];
    wire ir_mode = mcr_reg[SPMP_MCTL_IR];

    // read mux; unmapped addresses read zero
    wire [31:0] rd_value =
        hit_data ? {24'h000000, rx_data_reg} :
        hit_mctl ? {26'h0000000, mcr_reg} :
        hit_mstat ? {24'h000000, ms_cur_reg, ms_delta_reg} :
        hit_line ? {25'h0000000, strap_reg, ~fifo_out_valid & (tx_state_reg == SPMP_IDLE),
                    ~fifo_in_ready, rx_ovr_reg, rx_rdy_reg} :
        hit_div ? {16'h0000, div_reg} : 32'h00000000;
    wire [15:0] div_wr = (pwdata[15:0] < SPMP_DIV_MIN) ? SPMP_DIV_MIN : pwdata[15:0];

    // apb answer: one wait state, pready and data from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else if (clk_en) begin
            pready_reg <= pready_next;
            pslverr_reg <= pready_next & ~hit_any;
            if (pready_next) prdata_reg <= pwrite ? 32'h00000000 : rd_value;
        end
    end

    // software registers: control bits steer the pins and the line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mcr_reg <= SPMP_MCTL_RESET;
            div_reg <= DIV_RESET;
        end else if (clk_en && wr_fire) begin
            if (hit_mctl) mcr_reg <= pwdata[SPMP_MCTL_W-1:0];
            if (hit_div) div_reg <= div_wr;
        end
    end

    // modem status: in loop mode the control bits stand in for the modem, as a self-test path
    wire [3:0] ms_ext = {~carrier_detect_in_n, ~ring_indicate_in_n, ~set_ready_in_n, ~clear_to_send_in_n};
    wire [3:0] ms_loop = {1'b0, 1'b0, mcr_reg[SPMP_MCTL_DTR], mcr_reg[SPMP_MCTL_RTS]};
    wire [3:0] ms_in = loop_mode ? ms_loop : ms_ext;
    wire ms_clr = rd_fire & hit_mstat;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cur_reg <= 4'h0;
            ms_delta_reg <= 4'h0;
        end else if (clk_en) begin
            ms_cur_reg <= ms_in;
            // a change in the read cycle survives the clear
            ms_delta_reg <= (ms_clr ? 4'h0 : ms_delta_reg) | (ms_in ^ ms_cur_reg);
        end
    end

    // strap window follows host_bus_reset_n; the pins are released for the whole window
    wire hbr_rise = host_bus_reset_n & ~hbr_prev_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hbr_prev_reg <= 1'b1;
            strap_samp_reg <= 3'h0;
            strap_reg <= 3'h0;
            pins_oe_reg <= 1'b1;
        end else if (clk_en) begin
            hbr_prev_reg <= host_bus_reset_n;
            pins_oe_reg <= host_bus_reset_n;
            if (!host_bus_reset_n) begin
                strap_samp_reg <= {serial_tx_pin_in, send_request_pin_in, terminal_ready_pin_in};
            end
            if (hbr_rise) strap_reg <= strap_samp_reg;
        end
    end

    // pin drivers; mark on the data line in loop or infrared mode, handshakes inactive in loop mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_out_reg <= 1'b1;
            rts_n_reg <= 1'b1;
            dtr_n_reg <= 1'b1;
        end else if (clk_en) begin
            tx_out_reg <= tx_line_reg | ir_mode | loop_mode;
            rts_n_reg <= loop_mode | ~mcr_reg[SPMP_MCTL_RTS];
            dtr_n_reg <= loop_mode | ~mcr_reg[SPMP_MCTL_DTR];
        end
    end

    // transmit buffer; the shifter drains it only when idle
    wire tx_take = fifo_out_valid & (tx_state_reg == SPMP_IDLE);
    spmp_fifo #(
        .WIDTH(SPMP_DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .clk_en(clk_en),
        .in_valid(push_tx),
        .in_ready(fifo_in_ready),
        .in_data(pwdata[7:0]),
        .out_valid(fifo_out_valid),
        .out_ready(tx_take),
        .out_data(fifo_out_data)
    );

    // transmitter: start, eight data bits lsb first, stop; each bit lasts div_reg cycles
    wire tx_bit_end = (tx_cnt_reg == div_reg - 16'h0001);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_reg <= SPMP_IDLE;
            tx_cnt_reg <= 16'h0000;
            tx_bit_reg <= 3'h0;
            tx_sh_reg <= 8'h00;
            tx_line_reg <= 1'b1;
        end else if (clk_en) begin
            tx_cnt_reg <= (tx_state_reg == SPMP_IDLE || tx_bit_end) ? 16'h0000 : tx_cnt_reg + 16'h0001;
            case (tx_state_reg)
                SPMP_IDLE: begin
                    if (tx_take) begin
                        tx_sh_reg <= fifo_out_data;
                        tx_line_reg <= 1'b0;
                        tx_state_reg <= SPMP_START;
                    end
                end
                SPMP_START: begin
                    if (tx_bit_end) begin
                        tx_line_reg <= tx_sh_reg[0];
                        tx_bit_reg <= 3'h0;
                        tx_state_reg <= SPMP_BITS;
                    end
                end
                SPMP_BITS: begin
                    if (tx_bit_end) begin
                        tx_bit_reg <= tx_bit_reg + 3'h1;
                        tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
                        tx_line_reg <= (tx_bit_reg == 3'h7) ? 1'b1 : tx_sh_reg[1];
                        if (tx_bit_reg == 3'h7) tx_state_reg <= SPMP_STOP;
                    end
                end
                SPMP_STOP: begin
                    if (tx_bit_end) tx_state_reg <= SPMP_IDLE;
                end
                default: tx_state_reg <= SPMP_IDLE;
            endcase
        end
    end

    // receiver samples mid-bit; loop mode feeds it from the transmitter, not the pin
    wire rx_src = loop_mode ? tx_line_reg : serial_rx_in;
    wire rx_half = (rx_cnt_reg == {1'b0, div_reg[15:1]} - 16'h0002); // synchroniser and idle state eat two cycles
    wire rx_bit_end = (rx_cnt_reg == div_reg - 16'h0001);
    wire rx_clr = rd_fire & hit_data;
    wire rx_done = (rx_state_reg == SPMP_STOP) & rx_bit_end & rx_s_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_s_reg <= 1'b1;
            rx_state_reg <= SPMP_IDLE;
            rx_cnt_reg <= 16'h0000;
            rx_bit_reg <= 3'h0;
            rx_sh_reg <= 8'h00;
        end else if (clk_en) begin
            rx_s_reg <= rx_src;
            rx_cnt_reg <= (rx_state_reg == SPMP_IDLE || rx_bit_end || (rx_state_reg == SPMP_START && rx_half))
                ? 16'h0000 : rx_cnt_reg + 16'h0001;
            case (rx_state_reg)
                SPMP_IDLE: begin
                    if (!rx_s_reg) rx_state_reg <= SPMP_START;
                end
                SPMP_START: begin
                    // a start bit that is gone at mid-bit was a glitch
                    if (rx_half) rx_state_reg <= rx_s_reg ? SPMP_IDLE : SPMP_BITS;
                    rx_bit_reg <= 3'h0;
                end
                SPMP_BITS: begin
                    if (rx_bit_end) begin
                        rx_sh_reg <= {rx_s_reg, rx_sh_reg[7:1]};
                        rx_bit_reg <= rx_bit_reg + 3'h1;
                        if (rx_bit_reg == 3'h7) rx_state_reg <= SPMP_STOP;
                    end
                end
                SPMP_STOP: begin
                    if (rx_bit_end) rx_state_reg <= SPMP_IDLE;
                end
                default: rx_state_reg <= SPMP_IDLE;
            endcase
        end
    end

    // receive holding register; a new character wins over a read in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_reg <= 8'h00;
            rx_rdy_reg <= 1'b0;
            rx_ovr_reg <= 1'b0;
        end else if (clk_en) begin
            if (rx_done) rx_data_reg <= rx_sh_reg;
            rx_rdy_reg <= rx_done | (rx_rdy_reg & ~rx_clr);
            rx_ovr_reg <= (rx_done & rx_rdy_reg & ~rx_clr) | (rx_ovr_reg & ~(rd_fire & hit_line));
        end
    end

    // outputs, each straight from a flip-flop
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign serial_tx_out = tx_out_reg;
    assign serial_tx_oe = pins_oe_reg;
    assign send_request_out_n = rts_n_reg;
    assign send_request_oe = pins_oe_reg;
    assign terminal_ready_out_n = dtr_n_reg;
    assign terminal_ready_oe = pins_oe_reg;
    assign {strap_opt_c, strap_opt_b, strap_opt_a} = strap_reg;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ir_tx_mark: assert property (clk_en && ir_mode |=> serial_tx_out)
        else $error("transmit pin not at mark in infrared mode");
    a_tx_pin_release: assert property (clk_en && !host_bus_reset_n |=> !serial_tx_oe)
        else $error("transmit pin driven during strap window");
    a_hs_pin_release: assert property (clk_en && !host_bus_reset_n |=> !send_request_oe && !terminal_ready_oe)
        else $error("handshake pin driven during strap window");
    a_rts_follow: assert property (clk_en |=> send_request_out_n == ($past(loop_mode) | !$past(mcr_reg[SPMP_MCTL_RTS])))
        else $error("send-request output does not follow control bit");
    a_dtr_loop: assert property (clk_en && loop_mode |=> terminal_ready_out_n)
        else $error("terminal-ready active in loop mode");
    a_dsr_status: assert property (clk_en && !loop_mode |=> ms_cur_reg[SPMP_MS_DSR] == !$past(set_ready_in_n))
        else $error("set-ready status wrong");
    a_cts_status: assert property (clk_en && !loop_mode |=> ms_cur_reg[SPMP_MS_CTS] != $past(clear_to_send_in_n))
        else $error("clear-to-send status wrong");
    a_ri_status: assert property (clk_en && !loop_mode && !ring_indicate_in_n |=> ms_cur_reg[SPMP_MS_RI])
        else $error("ring-indicate status wrong");
    a_dcd_status: assert property (clk_en && !loop_mode && carrier_detect_in_n |=> !ms_cur_reg[SPMP_MS_DCD])
        else $error("carrier-detect status wrong");
    a_tx_start_bit: assert property (clk_en && tx_take ##1 clk_en |=> !serial_tx_out || $past(ir_mode | loop_mode))
        else $error("start bit not sent after taking a character");
    a_strap_latch: assert property (clk_en && hbr_rise |=> strap_reg == $past(strap_samp_reg))
        else $error("straps not latched at window close");
    a_pins_return: assert property (clk_en && hbr_rise |=> serial_tx_oe && send_request_oe && terminal_ready_oe)
        else $error("pins not driving after window close");
    a_apb_unmapped: assert property (pready && !hit_any && acc |-> pslverr)
        else $error("unmapped access without error");

    c_strap_window: cover property (clk_en && hbr_rise);
    c_tx_char: cover property (clk_en && tx_take);
    c_rx_char: cover property (clk_en && rx_done);
    c_fifo_full_stall: cover property (acc && wr_blocked ##1 acc && wr_blocked);
endmodule // spmp_port

// ===== testbench/serial_port_modem_pins_test.sv
// self-checking bench for the serial port: apb master, strap drivers, modem model, queue-based expectations
// assumes the port runs with a bit time of 4 pclk cycles and clk_en held high
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin num_errors++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module serial_port_modem_pins_test;
    import spmp_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, host_bus_reset_n = 1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, tx, tx_oe, rts, rts_oe, dtr, dtr_oe, sa, sb, sc;
    logic [2:0] strap_drv = 3'h0;
    logic [3:0] st;
    logic [7:0] exp_q[$];
    wire [3:0] stat_n;
    wire rx;
    int num_errors = 0, cmp_count = 0;
    always #12.5 pclk = ~pclk;
    spmp_port #(.DIV_RESET(16'h0004)) u_spmp_port (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .host_bus_reset_n(host_bus_reset_n), .serial_rx_in(rx), .serial_tx_out(tx),
        .serial_tx_oe(tx_oe), .serial_tx_pin_in(tx_oe ? tx : strap_drv[2]), .send_request_out_n(rts),
        .send_request_oe(rts_oe), .send_request_pin_in(rts_oe ? rts : strap_drv[1]),
        .terminal_ready_out_n(dtr), .terminal_ready_oe(dtr_oe), .terminal_ready_pin_in(dtr_oe ? dtr : strap_drv[0]),
        .set_ready_in_n(stat_n[1]), .clear_to_send_in_n(stat_n[0]), .ring_indicate_in_n(stat_n[2]),
        .carrier_detect_in_n(stat_n[3]), .strap_opt_a(sa), .strap_opt_b(sb), .strap_opt_c(sc));
    spmp_modem #(.DIV(4)) u_spmp_modem (.pclk(pclk), .tx_line(tx), .rx_line(rx), .stat_n(stat_n));
    task print_verdict;
        $display("errors %0d of %0d comparisons", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one apb transfer; no cycle count assumed, only the bench's own bound
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 400);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (pready !== 1'b1) begin num_errors++; print_verdict(); end
        @(posedge pclk);
    endtask
    task wait_clk(input int n);
        repeat (n) @(posedge pclk);
    endtask
    initial begin
        void'($urandom(41));
        wait_clk(3);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("tx idle", 1'b1, tx)
        `CHK("rts reset", 1'b1, rts)
        `CHK("dtr reset", 1'b1, dtr)
        // every mix of terminal-ready, send-request and loop
        for (int v = 0; v < 8; v++) begin
            apb(1, SPMP_OFF_MCTL, {27'h0, v[2], 2'h0, v[1:0]});
            wait_clk(1); // the pin flop follows the control register one edge later
            `CHK("rts pin", v[2] | ~v[1], rts)
            `CHK("dtr pin", v[2] | ~v[0], dtr)
        end
        // loop mode with both handshakes set: status mirrors them, so leave loop before the pin test
        apb(0, SPMP_OFF_MSTAT, 32'h0);
        `CHK("loop status", 4'h3, rd[7:4])
        apb(1, SPMP_OFF_MCTL, 32'h0);
        // status pins read back inverted in the current-level nibble
        for (int k = 0; k < 4; k++) begin
            st = 4'($urandom);
            u_spmp_modem.set_stat(st);
            wait_clk(3);
            apb(0, SPMP_OFF_MSTAT, 32'h0);
            `CHK("status", ~st, rd[7:4])
        end
        apb(0, 8'h20, 32'h0);
        `CHK("unmapped err", 1'b1, er)
        // a divisor below the minimum is clamped; the bit time stays at the bench's 4 cycles
        apb(1, SPMP_OFF_DIV, 32'h2);
        apb(0, SPMP_OFF_DIV, 32'h0);
        `CHK("div clamp", {16'h0000, SPMP_DIV_MIN}, rd)
        // strap window: pins released, sampled, latched at release
        strap_drv <= 3'($urandom);
        host_bus_reset_n <= 1'b0;
        wait_clk(3);
        `CHK("tx oe", 1'b0, tx_oe)
        `CHK("ctl oe", 2'b00, {rts_oe, dtr_oe})
        host_bus_reset_n <= 1'b1;
        wait_clk(3);
        `CHK("straps", strap_drv, {sc, sb, sa})
        `CHK("oe back", 3'h7, {tx_oe, rts_oe, dtr_oe})
        apb(0, SPMP_OFF_LINE, 32'h0);
        `CHK("line straps", strap_drv, rd[6:4])
        u_spmp_modem.got_q.delete();
        // infrared mode: a frame is shifted but the pin stays at mark
        apb(1, SPMP_OFF_MCTL, 32'h20);
        apb(1, SPMP_OFF_DATA, 32'h00);
        for (int c = 0; c < 60; c++) begin
            @(posedge pclk);
            if (tx !== 1'b1) `CHK("tx in infrared", 1'b1, tx)
        end
        apb(1, SPMP_OFF_MCTL, 32'h0);
        // overfill the fifo; pushes past the depth stall until the line drains
        for (int j = 0; j < 22; j++) begin
            exp_q.push_back(8'($urandom));
            apb(1, SPMP_OFF_DATA, {24'h0, exp_q[j]});
        end
        for (int c = 0; c < 2000 && u_spmp_modem.got_q.size() < 22; c++) @(posedge pclk);
        `CHK("frames sent", 22, u_spmp_modem.got_q.size())
        foreach (exp_q[j]) `CHK("tx byte", exp_q[j], u_spmp_modem.got_q[j])
        // receive, answered promptly and then slowly
        for (int g = 1; g < 40; g += 30) begin
            exp_q[0] = 8'($urandom);
            u_spmp_modem.send(exp_q[0], g);
            rd = 32'h0;
            for (int c = 0; c < 50 && rd[SPMP_LS_RXRDY] !== 1'b1; c++) apb(0, SPMP_OFF_LINE, 32'h0);
            `CHK("rx ready", 1'b1, rd[SPMP_LS_RXRDY])
            apb(0, SPMP_OFF_DATA, 32'h0);
            `CHK("rx byte", exp_q[0], rd[7:0])
        end
        print_verdict();
    end
endmodule // serial_port_modem_pins_test

// ===== testbench/spmp_modem.sv
// modem-side model: decodes 8N1 frames from the port, sends frames back, drives the status lines
// assumes a bit time of DIV pclk cycles; all drives change by non-blocking assignment after a rising edge
`timescale 1ns/10ps
module spmp_modem #(
    parameter int DIV = 4
) (
    // clock
    input wire logic pclk,
    // serial lines
    input wire logic tx_line,
    output logic rx_line,
    // status lines, active low, order cts dsr ri dcd
    output logic [3:0] stat_n
);
    logic [7:0] got_q[$];
    logic [7:0] b;
    initial rx_line = 1'b1;
    initial stat_n = 4'hf;
    // sample in mid-bit; a start bit gone by then is a glitch, not a frame
    initial begin
        forever begin
            @(negedge tx_line);
            repeat (DIV / 2) @(posedge pclk);
            if (tx_line === 1'b0) begin
                for (int i = 0; i < 8; i++) begin
                    repeat (DIV) @(posedge pclk);
                    b[i] = tx_line;
                end
                repeat (DIV) @(posedge pclk);
                got_q.push_back(b);
            end
        end
    end
    // gap lets the modem answer promptly or slowly
    task send(input logic [7:0] d, input int gap);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        repeat (gap) @(posedge pclk);
        for (int i = 0; i < 10; i++) begin
            rx_line <= f[i];
            repeat (DIV) @(posedge pclk);
        end
    endtask
    task set_stat(input logic [3:0] v);
        stat_n <= v;
    endtask
endmodule // spmp_modem
